// ==== hw/jdbg_pkg.sv ====
// Constants, field layouts and TAP state encoding for the JTAG debug port.
package jdbg_pkg;
    localparam int IR_W   = 5;
    localparam int ABITS  = 7;
    localparam int DBITS  = 32;
    localparam int OPW    = 2;
    localparam int SCAN_W = ABITS + DBITS + OPW;
    localparam int HA_W   = 12;
    localparam int PB_N   = 16;
    localparam int PB_IW  = 4;
    localparam int ROM_N  = 4;
    localparam int ROM_IW = 2;
    localparam int TMS_RESET_N = 5;

    localparam logic [IR_W-1:0] IR_IDCODE  = 5'h01;
    localparam logic [IR_W-1:0] IR_DMI     = 5'h11;
    localparam logic [IR_W-1:0] IR_CAPTURE = 5'h01;
    localparam logic [OPW-1:0]  OP_NOP     = 2'h0;
    localparam logic [OPW-1:0]  OP_READ    = 2'h1;
    localparam logic [OPW-1:0]  OP_WRITE   = 2'h2;
    localparam logic [OPW-1:0]  OP_OK      = 2'h0;

    localparam logic [ABITS-1:0] DM_DATA0   = 7'h04;
    localparam logic [ABITS-1:0] DM_CONTROL = 7'h10;
    localparam logic [ABITS-1:0] DM_STATUS  = 7'h11;
    localparam logic [ABITS-1:0] DM_ABSCS   = 7'h16;
    localparam logic [ABITS-1:0] DM_COMMAND = 7'h17;
    localparam logic [ABITS-1:0] DM_PROGBUF = 7'h20;

    localparam logic [HA_W-1:0] HA_ZERO     = 12'h000;
    localparam logic [HA_W-1:0] HA_FLAG_LO  = 12'h100;
    localparam logic [HA_W-1:0] HA_FLAG_HI  = 12'h110;
    localparam logic [HA_W-1:0] HA_HALTED   = 12'h100;
    localparam logic [HA_W-1:0] HA_RESUMING = 12'h104;
    localparam logic [HA_W-1:0] HA_DONE     = 12'h108;
    localparam logic [HA_W-1:0] HA_PROGBUF  = 12'h300;
    localparam logic [HA_W-1:0] HA_DATA0    = 12'h340;
    localparam logic [HA_W-1:0] HA_GO       = 12'h400;
    localparam logic [HA_W-1:0] HA_ROM      = 12'h800;

    localparam int CMD_TYPE_LSB = 24;
    localparam int CMD_WR_BIT   = 16;
    localparam int GPR_LSB      = 5;
    localparam logic [15:0] CMD_GPR_BASE = 16'h1000;
    localparam int HALTREQ_BIT  = 31;
    localparam int ST_AUTH      = 7;
    localparam int ST_ANYHALT   = 8;
    localparam int ST_ALLHALT   = 9;
    localparam int ST_ANYRUN    = 10;
    localparam int ST_ALLRUN    = 11;
    localparam logic [3:0] ST_VERSION = 4'h2;
    localparam int AB_ERR_LSB   = 8;
    localparam int AB_BUSY      = 12;
    localparam int AB_PBSZ_LSB  = 24;
    localparam logic [3:0] AB_DATACOUNT = 4'h1;
    localparam logic [2:0] CMDERR_NONE  = 3'h0;
    localparam logic [2:0] CMDERR_BUSY  = 3'h1;
    localparam logic [2:0] CMDERR_UNSUP = 3'h2;
    localparam logic [2:0] CMDERR_HALT  = 3'h4;

    typedef enum logic [15:0] {
        TLR    = 16'h0001, RTI    = 16'h0002, SEL_DR = 16'h0004,
        CAP_DR = 16'h0008, SH_DR  = 16'h0010, EX1_DR = 16'h0020,
        PA_DR  = 16'h0040, EX2_DR = 16'h0080, UPD_DR = 16'h0100,
        SEL_IR = 16'h0200, CAP_IR = 16'h0400, SH_IR  = 16'h0800,
        EX1_IR = 16'h1000, PA_IR  = 16'h2000, EX2_IR = 16'h4000,
        UPD_IR = 16'h8000
    } tap_state_e;
endpackage

// ==== hw/jtag_debug_port.sv ====
// JTAG test access port, debug transport and debug module memory map.

// Function
// - Sixteen-state TAP advanced on test clock by mode-select; low test reset forces reset.
// - Power-on reset resets all debug port logic and yields an internal port reset.
// - Port reset clears transport and module; module reset passes a synchronizer.
// - Five test clocks with mode-select high reset only the transport.
// - Transport logic runs on the main clock from sampled test clock edges; the test clock must stay well below it.
// - Bypass and identification instructions; identification shifts a fixed 32-bit code.
// - Debug instruction puts the debug scan register between data in and out.
// - Scan register holds 2-bit op, 7-bit address, 32-bit data; one scan, one access.
// - Sixteen-word program buffer lives in the 0x300-0x33F region.
// - One 32-bit data word carries access-register command operands.
// - Abstract commands allow only register access while halted.
// - Program buffer and data word are plain contiguous read/write storage.
// - Module status register never shows the hart-has-reset bits.
// - Read-only debug routine region at 0x800-0xFFF, partly populated.
// - Per-hart flags at 0x100-0x110 and 0x400-0x7FF for the routines only.
// - Address zero reads zero and ignores writes.
// - Only debug-mode hart or transport accesses are served; others refused.
module jtag_debug_port #(
    parameter logic [31:0] IDCODE_VAL = 32'h1000_0001 // Arbitrary value.
) (
    input  wire logic                        I_MCLK,
    input  wire logic                        I_RESET,
    input  wire logic                        I_TCK,
    input  wire logic                        I_TMS,
    input  wire logic                        I_TDI,
    input  wire logic                        I_TRST_N,
    output logic                             O_TDO,
    output logic                             O_TDO_OE,
    input  wire logic                        I_HART_REQ,
    input  wire logic                        I_HART_WE,
    input  wire logic                        I_HART_DEBUG,
    input  wire logic [jdbg_pkg::HA_W-1:0]   I_HART_ADDR,
    input  wire logic [jdbg_pkg::DBITS-1:0]  I_HART_WDATA,
    output logic [jdbg_pkg::DBITS-1:0]       O_HART_RDATA,
    output logic                             O_HART_ACK,
    output logic                             O_HART_ERR,
    output logic                             O_HALT_REQ
);
    import jdbg_pkg::*;

    localparam logic [DBITS-1:0] ROM_IMG [ROM_N] = '{
        32'h0000_0013, 32'h0000_0013, 32'h0000_0013, 32'h7B20_0073};

    logic [1:0]              tck_sy_q, tms_sy_q, tdi_sy_q, trst_sy_q;
    logic                    tck_prev_q, tck_rise, tck_fall, tms, tdi;
    logic [1:0]              dm_rst_q;
    logic                    dm_rst;
    tap_state_e              state_q;
    logic [IR_W-1:0]         ir_q, ir_sh_q;
    logic [SCAN_W-1:0]       dr_q;
    logic                    dmi_req_q;
    logic [OPW-1:0]          dmi_op_q;
    logic [ABITS-1:0]        dmi_addr_q;
    logic [DBITS-1:0]        dmi_wdata_q, dmi_rdata_q, dmi_rd;
    logic [DBITS-1:0]        progbuf_q [PB_N];
    logic [DBITS-1:0]        data0_q, hart_rd;
    logic                    halted_q, go_q, cmd_wr_q, haltreq_q;
    logic [GPR_LSB-1:0]      cmd_regno_q;
    logic [2:0]              cmderr_q;
    logic                    dmi_wr, cmd_wr, cmd_ok, h_acc, h_wr, h_pb, h_rom;
    logic [2:0]              tms_ones_q;

    function automatic tap_state_e tap_next(tap_state_e s, logic m);
        tap_next = TLR;
        unique case (s)
            TLR:    tap_next = m ? TLR : RTI;
            RTI:    tap_next = m ? SEL_DR : RTI;
            SEL_DR: tap_next = m ? SEL_IR : CAP_DR;
            CAP_DR: tap_next = m ? EX1_DR : SH_DR;
            SH_DR:  tap_next = m ? EX1_DR : SH_DR;
            EX1_DR: tap_next = m ? UPD_DR : PA_DR;
            PA_DR:  tap_next = m ? EX2_DR : PA_DR;
            EX2_DR: tap_next = m ? UPD_DR : SH_DR;
            UPD_DR: tap_next = m ? SEL_DR : RTI;
            SEL_IR: tap_next = m ? TLR : CAP_IR;
            CAP_IR: tap_next = m ? EX1_IR : SH_IR;
            SH_IR:  tap_next = m ? EX1_IR : SH_IR;
            EX1_IR: tap_next = m ? UPD_IR : PA_IR;
            PA_IR:  tap_next = m ? EX2_IR : PA_IR;
            EX2_IR: tap_next = m ? UPD_IR : SH_IR;
            UPD_IR: tap_next = m ? SEL_DR : RTI;
        endcase
    endfunction

    // Pins cross on two flops; test clock edges are found after them.
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            tck_sy_q   <= 2'h0;
            tms_sy_q   <= 2'h3;
            tdi_sy_q   <= 2'h0;
            trst_sy_q  <= 2'h3;
            tck_prev_q <= 1'b0;
        end else begin
            tck_sy_q   <= {tck_sy_q[0], I_TCK};
            tms_sy_q   <= {tms_sy_q[0], I_TMS};
            tdi_sy_q   <= {tdi_sy_q[0], I_TDI};
            trst_sy_q  <= {trst_sy_q[0], I_TRST_N};
            tck_prev_q <= tck_sy_q[1];
        end
    end
    assign tck_rise = tck_sy_q[1] & ~tck_prev_q;
    assign tck_fall = ~tck_sy_q[1] & tck_prev_q;
    assign tms      = tms_sy_q[1];
    assign tdi      = tdi_sy_q[1];

    // Module reset is held two cycles past the port reset.
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            dm_rst_q <= 2'h3;
        end else begin
            dm_rst_q <= {dm_rst_q[0], 1'b0};
        end
    end
    assign dm_rst = dm_rst_q[1];

    always_ff @(posedge I_MCLK) begin
        if (I_RESET || !trst_sy_q[1]) begin
            state_q <= TLR;
        end else if (tck_rise) begin
            state_q <= tap_next(state_q, tms);
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RESET || state_q == TLR) begin
            ir_q    <= IR_IDCODE;
            ir_sh_q <= '0;
        end else if (tck_rise) begin
            if (state_q == CAP_IR) begin
                ir_sh_q <= IR_CAPTURE;
            end else if (state_q == SH_IR) begin
                ir_sh_q <= {tdi, ir_sh_q[IR_W-1:1]};
            end else if (state_q == UPD_IR) begin
                ir_q <= ir_sh_q;
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            dr_q <= '0;
        end else if (tck_rise && state_q == CAP_DR) begin
            if (ir_q == IR_IDCODE) begin
                dr_q <= {{(SCAN_W-DBITS){1'b0}}, IDCODE_VAL};
            end else if (ir_q == IR_DMI) begin
                dr_q <= {dmi_addr_q, dmi_rdata_q, OP_OK};
            end else begin
                dr_q <= '0;
            end
        end else if (tck_rise && state_q == SH_DR) begin
            if (ir_q == IR_IDCODE) begin
                dr_q <= {{(SCAN_W-DBITS){1'b0}}, tdi, dr_q[DBITS-1:1]};
            end else if (ir_q == IR_DMI) begin
                dr_q <= {tdi, dr_q[SCAN_W-1:1]};
            end else begin
                dr_q <= {{(SCAN_W-1){1'b0}}, tdi};
            end
        end
    end

    // Data out changes on the falling test clock edge.
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            O_TDO    <= 1'b0;
            O_TDO_OE <= 1'b0;
        end else if (tck_fall) begin
            O_TDO    <= (state_q == SH_IR) ? ir_sh_q[0] : dr_q[0];
            O_TDO_OE <= (state_q == SH_IR) || (state_q == SH_DR);
        end
    end

    // A finished scan launches one access as a single-cycle request.
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            dmi_req_q   <= 1'b0;
            dmi_op_q    <= OP_NOP;
            dmi_addr_q  <= '0;
            dmi_wdata_q <= '0;
        end else begin
            dmi_req_q <= tck_rise && state_q == UPD_DR && ir_q == IR_DMI
                         && dr_q[OPW-1:0] != OP_NOP;
            if (tck_rise && state_q == UPD_DR && ir_q == IR_DMI) begin
                dmi_op_q    <= dr_q[OPW-1:0];
                dmi_wdata_q <= dr_q[OPW +: DBITS];
                dmi_addr_q  <= dr_q[OPW+DBITS +: ABITS];
            end
        end
    end

    assign dmi_wr = dmi_req_q && dmi_op_q == OP_WRITE;
    assign cmd_wr = dmi_wr && dmi_addr_q == DM_COMMAND;
    assign cmd_ok = dmi_wdata_q[DBITS-1:CMD_TYPE_LSB] == '0
        && dmi_wdata_q[15:GPR_LSB] == CMD_GPR_BASE[15:GPR_LSB];

    always_comb begin
        dmi_rd = '0;
        if (dmi_addr_q == DM_DATA0) begin
            dmi_rd = data0_q;
        end else if (dmi_addr_q == DM_CONTROL) begin
            dmi_rd[HALTREQ_BIT] = haltreq_q;
            dmi_rd[0] = 1'b1;
        end else if (dmi_addr_q == DM_STATUS) begin
            dmi_rd[3:0]        = ST_VERSION;
            dmi_rd[ST_AUTH]    = 1'b1;
            dmi_rd[ST_ANYHALT] = halted_q;
            dmi_rd[ST_ALLHALT] = halted_q;
            dmi_rd[ST_ANYRUN]  = ~halted_q;
            dmi_rd[ST_ALLRUN]  = ~halted_q;
        end else if (dmi_addr_q == DM_ABSCS) begin
            dmi_rd[3:0] = AB_DATACOUNT;
            dmi_rd[AB_ERR_LSB +: 3] = cmderr_q;
            dmi_rd[AB_BUSY] = go_q;
            dmi_rd[AB_PBSZ_LSB +: 5] = 5'(PB_N);
        end else if (dmi_addr_q[ABITS-1:PB_IW] == DM_PROGBUF[ABITS-1:PB_IW])
        begin
            dmi_rd = progbuf_q[dmi_addr_q[PB_IW-1:0]];
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (dm_rst) begin
            dmi_rdata_q <= '0;
        end else if (dmi_req_q && dmi_op_q == OP_READ) begin
            dmi_rdata_q <= dmi_rd;
        end
    end

    assign h_acc = I_HART_REQ && I_HART_DEBUG;
    assign h_wr  = h_acc && I_HART_WE;
    assign h_pb  = I_HART_ADDR[HA_W-1:PB_IW+2] == HA_PROGBUF[HA_W-1:PB_IW+2];
    assign h_rom = I_HART_ADDR >= HA_ROM;

    // Transport writes take priority over hart writes in the same cycle.
    always_ff @(posedge I_MCLK) begin
        if (dm_rst) begin
            for (int i = 0; i < PB_N; i++) begin
                progbuf_q[i] <= '0;
            end
            data0_q <= '0;
        end else if (dmi_wr && dmi_addr_q[ABITS-1:PB_IW]
                     == DM_PROGBUF[ABITS-1:PB_IW]) begin
            progbuf_q[dmi_addr_q[PB_IW-1:0]] <= dmi_wdata_q;
        end else if (dmi_wr && dmi_addr_q == DM_DATA0) begin
            data0_q <= dmi_wdata_q;
        end else if (h_wr && h_pb) begin
            progbuf_q[I_HART_ADDR[2 +: PB_IW]] <= I_HART_WDATA;
        end else if (h_wr && I_HART_ADDR == HA_DATA0) begin
            data0_q <= I_HART_WDATA;
        end
    end

    always_comb begin
        hart_rd = '0;
        if (h_pb) begin
            hart_rd = progbuf_q[I_HART_ADDR[2 +: PB_IW]];
        end else if (I_HART_ADDR == HA_DATA0) begin
            hart_rd = data0_q;
        end else if (I_HART_ADDR == HA_GO) begin
            hart_rd[GPR_LSB+2:0] = {cmd_wr_q, cmd_regno_q, 1'b0, go_q};
        end else if (h_rom && I_HART_ADDR[HA_W-2:ROM_IW+2] == '0) begin
            hart_rd = ROM_IMG[I_HART_ADDR[2 +: ROM_IW]];
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (dm_rst) begin
            O_HART_ACK   <= 1'b0;
            O_HART_ERR   <= 1'b0;
            O_HART_RDATA <= '0;
        end else begin
            O_HART_ACK   <= h_acc;
            O_HART_ERR   <= I_HART_REQ && !I_HART_DEBUG;
            O_HART_RDATA <= (h_acc && !I_HART_WE) ? hart_rd : '0;
        end
    end

    // Flags and abstract command state; a set wins over a clear.
    always_ff @(posedge I_MCLK) begin
        if (dm_rst) begin
            halted_q    <= 1'b0;
            go_q        <= 1'b0;
            cmd_wr_q    <= 1'b0;
            cmd_regno_q <= '0;
            cmderr_q    <= CMDERR_NONE;
            haltreq_q   <= 1'b0;
        end else begin
            if (h_wr && I_HART_ADDR == HA_HALTED) begin
                halted_q <= 1'b1;
            end else if (h_wr && I_HART_ADDR == HA_RESUMING) begin
                halted_q <= 1'b0;
            end
            if (dmi_wr && dmi_addr_q == DM_CONTROL) begin
                haltreq_q <= dmi_wdata_q[HALTREQ_BIT];
            end
            if (cmd_wr && cmderr_q == CMDERR_NONE) begin
                if (go_q) begin
                    cmderr_q <= CMDERR_BUSY;
                end else if (!cmd_ok) begin
                    cmderr_q <= CMDERR_UNSUP;
                end else if (!halted_q) begin
                    cmderr_q <= CMDERR_HALT;
                end else begin
                    go_q        <= 1'b1;
                    cmd_wr_q    <= dmi_wdata_q[CMD_WR_BIT];
                    cmd_regno_q <= dmi_wdata_q[GPR_LSB-1:0];
                end
            end else begin
                if (h_wr && I_HART_ADDR == HA_DONE) begin
                    go_q <= 1'b0;
                end
                if (dmi_wr && dmi_addr_q == DM_ABSCS) begin
                    cmderr_q <= cmderr_q & ~dmi_wdata_q[AB_ERR_LSB +: 3];
                end
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            O_HALT_REQ <= 1'b0;
        end else begin
            O_HALT_REQ <= haltreq_q;
        end
    end

    // Checker helper: consecutive rising test clocks with mode-select high.
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            tms_ones_q <= '0;
        end else if (tck_rise) begin
            tms_ones_q <= !tms ? 3'h0 :
                (tms_ones_q == 3'(TMS_RESET_N)) ? tms_ones_q : tms_ones_q + 3'h1;
        end
    end

    default clocking cb @(posedge I_MCLK); endclocking

    a_trst_forces_reset: assert property (disable iff (I_RESET)
        !trst_sy_q[1] |=> state_q == TLR) else $error("TAP not reset");
    a_tms_five_reset: assert property (disable iff (I_RESET)
        tms_ones_q == 3'(TMS_RESET_N) |-> state_q == TLR)
        else $error("five TMS highs did not reset TAP");
    a_dm_reset_hold: assert property (
        I_RESET |=> dm_rst ##1 dm_rst) else $error("module reset too short");
    a_tlr_selects_id: assert property (disable iff (I_RESET)
        state_q == TLR |=> ir_q == IR_IDCODE) else $error("IR not IDCODE");
    a_id_capture: assert property (disable iff (I_RESET)
        tck_rise && state_q == CAP_DR && ir_q == IR_IDCODE
        |=> dr_q[DBITS-1:0] == IDCODE_VAL) else $error("bad ID capture");
    a_scan_launch: assert property (disable iff (I_RESET)
        tck_rise && state_q == UPD_DR && ir_q == IR_DMI
        && dr_q[OPW-1:0] == OP_READ |=> dmi_req_q ##1 dmi_rdata_q == $past(dmi_rd))
        else $error("scan op not executed");
    a_zero_reads: assert property (disable iff (I_RESET || dm_rst)
        h_acc && !I_HART_WE && I_HART_ADDR == HA_ZERO
        |=> O_HART_ACK && O_HART_RDATA == '0) else $error("zero not zero");
    a_refuse_nondebug: assert property (disable iff (I_RESET || dm_rst)
        I_HART_REQ && !I_HART_DEBUG |=> O_HART_ERR && !O_HART_ACK)
        else $error("non-debug access served");
    a_havereset_zero: assert property (disable iff (I_RESET || dm_rst)
        dmi_req_q && dmi_op_q == OP_READ && dmi_addr_q == DM_STATUS
        |=> dmi_rdata_q[19:18] == 2'h0) else $error("havereset bits set");
    a_cmd_needs_halt: assert property (disable iff (I_RESET || dm_rst)
        cmd_wr && cmd_ok && !halted_q && !go_q && cmderr_q == CMDERR_NONE
        |=> cmderr_q == CMDERR_HALT && !go_q) else $error("command ran");

    c_dmi_write: cover property (disable iff (I_RESET) dmi_wr);
    c_cmd_accept: cover property (disable iff (I_RESET) cmd_wr ##1 go_q);
    c_id_shift: cover property (disable iff (I_RESET)
        state_q == SH_DR && ir_q == IR_IDCODE && O_TDO_OE);
endmodule

// ==== dv/jtag_probe.sv ====
// Behavioural JTAG probe that walks the test access port from outside.
module jtag_probe (
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    output logic      o_trst_n,
    input  wire logic i_tdo
);
    timeunit 1ns;
    timeprecision 100ps;
    logic filler;

    initial begin
        o_tck    = 1'b0;
        o_tms    = 1'b1;
        o_tdi    = 1'b0;
        o_trst_n = 1'b1;
        filler   = 1'b0;
    end

    // One test clock period; the clock stands low between frames.
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #80;
        tdo = i_tdo;
        o_tck = 1'b1;
        #80;
        o_tck = 1'b0;
    endtask

    // Outside shifting the data line toggles so no stale bit is seen.
    task automatic nav(input logic tms);
        logic dummy;
        filler = ~filler;
        tick(tms, filler, dummy);
    endtask

    task automatic reset5();
        repeat (5) nav(1'b1);
        nav(1'b0);
    endtask

    task automatic trst();
        o_trst_n = 1'b0;
        #100;
        o_trst_n = 1'b1;
        nav(1'b0);
    endtask

    // From idle to shift, n bits LSB first, update, back to idle.
    task automatic scan(input bit ir, input int n, input logic [40:0] din,
                        output logic [40:0] dout);
        logic b;
        dout = '0;
        nav(1'b1);
        if (ir) nav(1'b1);
        nav(1'b0);
        nav(1'b0);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], b);
            dout[i] = b;
        end
        nav(1'b1);
        nav(1'b0);
    endtask
endmodule

// ==== dv/jtag_debug_port_tb_top.sv ====
// Self-checking bench for the JTAG debug port with a probe model.
module jtag_debug_port_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import jdbg_pkg::*;
    localparam logic [31:0] ID = 32'h0C0F_FEE1; // Arbitrary value.
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        tck, tms, tdi, trst_n, tdo, tdo_oe;
    logic        req = 1'b0;
    logic        we = 1'b0;
    logic        dbg = 1'b0;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, hd, d0, w;
    logic        ack, err, halt, hack, herr;
    logic [40:0] dq;
    int          seed, fails, n_tests, cyc;

    always #5 mclk = ~mclk;

    // Data out is released outside shifting; a pull-up then holds it high.
    wire         tdo_pin = tdo_oe ? tdo : 1'b1;

    jtag_probe probe (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
        .o_trst_n(trst_n), .i_tdo(tdo_pin));

    jtag_debug_port #(.IDCODE_VAL(ID)) DUT (.I_MCLK(mclk), .I_RESET(rst),
        .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi), .I_TRST_N(trst_n),
        .O_TDO(tdo), .O_TDO_OE(tdo_oe), .I_HART_REQ(req), .I_HART_WE(we),
        .I_HART_DEBUG(dbg), .I_HART_ADDR(addr), .I_HART_WDATA(wdata),
        .O_HART_RDATA(rdata), .O_HART_ACK(ack), .O_HART_ERR(err),
        .O_HALT_REQ(halt));

    task automatic chk(string what, logic [40:0] exp, logic [40:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic hart(input logic wr, input logic dm, input logic [11:0] a,
                        input logic [31:0] wd);
        @(posedge mclk);
        #1;
        req = 1'b1;
        we = wr;
        dbg = dm;
        addr = a;
        wdata = wd;
        @(posedge mclk);
        #1;
        req = 1'b0;
        addr = ~a;
        wdata = ~wd;
        hd = rdata;
        hack = ack;
        herr = err;
    endtask

    function automatic logic [40:0] word(logic [6:0] a, logic [31:0] d,
                                         logic [1:0] op);
        return {a, d, op};
    endfunction

    task automatic dmi(input logic [1:0] op, input logic [6:0] a,
                       input logic [31:0] d);
        probe.scan(1'b0, 41, word(a, d, op), dq);
    endtask

    task automatic dmi_rd(input logic [6:0] a);
        dmi(OP_READ, a, 32'h0);
        dmi(OP_NOP, a, 32'h0);
    endtask

    task automatic ir(input logic [4:0] code);
        probe.scan(1'b1, 5, {36'h0, code}, dq);
        chk("ir capture", {36'h0, IR_CAPTURE}, dq);
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 80000) begin
            fails++;
            $display("[ERR] run expected finish seen timeout");
            results();
        end
    end

    initial begin
        seed = 5465;
        repeat (8) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (4) @(posedge mclk);
        probe.reset5();
        probe.scan(1'b0, 32, 41'h0, dq);
        chk("idcode", {9'h0, ID}, dq);
        ir(5'h1F);
        w = $random(seed);
        probe.scan(1'b0, 9, {32'h0, w[8:0]}, dq);
        chk("bypass", {32'h0, w[7:0], 1'b0}, dq);
        $display("test ids done");
        ir(IR_DMI);
        d0 = $random(seed);
        dmi(OP_WRITE, DM_DATA0, d0);
        dmi_rd(DM_DATA0);
        chk("dmi data0", word(DM_DATA0, d0, OP_OK), dq);
        hart(1'b0, 1'b1, HA_DATA0, 32'h0);
        chk("hart data0", d0, hd);
        chk("hart served", 2'b10, {hack, herr});
        for (int k = 0; k < 16; k += 5) begin
            w = $random(seed);
            dmi(OP_WRITE, 7'(DM_PROGBUF + k), w);
            hart(1'b0, 1'b1, 12'(HA_PROGBUF + 4 * k), 32'h0);
            chk("progbuf", w, hd);
        end
        hart(1'b1, 1'b1, 12'(HA_DATA0 - 4), ~d0);
        dmi_rd(7'(DM_PROGBUF + 15));
        chk("progbuf top", word(7'(DM_PROGBUF + 15), ~d0, OP_OK), dq);
        $display("test storage done");
        hart(1'b1, 1'b0, HA_DATA0, ~d0);
        chk("refuse err", 2'b01, {hack, herr});
        hart(1'b0, 1'b1, HA_DATA0, 32'h0);
        chk("refused write", d0, hd);
        hart(1'b1, 1'b1, HA_ZERO, $random(seed));
        hart(1'b0, 1'b1, HA_ZERO, 32'h0);
        chk("safe zero", 32'h0, hd);
        hart(1'b0, 1'b1, 12'(HA_ROM + 4), 32'h0);
        w = hd;
        hart(1'b1, 1'b1, 12'(HA_ROM + 4), ~w);
        hart(1'b0, 1'b1, 12'(HA_ROM + 4), 32'h0);
        chk("rom", w, hd);
        $display("test hart map done");
        for (int m = 0; m < 2; m++) begin
            ir(5'h1F);
            if (m == 0) probe.reset5();
            else probe.trst();
            probe.scan(1'b0, 32, 41'h0, dq);
            chk("tap reset idcode", {9'h0, ID}, dq);
        end
        hart(1'b0, 1'b1, HA_DATA0, 32'h0);
        chk("data0 kept", d0, hd);
        $display("test tap reset done");
        ir(IR_DMI);
        dmi_rd(DM_STATUS);
        chk("status reset bits", 2'b00, dq[21:20]);
        dmi(OP_WRITE, DM_CONTROL, 32'h8000_0001);
        chk("halt req", 1'b1, halt);
        dmi(OP_WRITE, DM_CONTROL, 32'h0000_0001);
        chk("halt req off", 1'b0, halt);
        dmi(OP_WRITE, DM_COMMAND, 32'h0001_1005);
        dmi_rd(DM_ABSCS);
        chk("cmderr halt", CMDERR_HALT, dq[12:10]);
        hart(1'b1, 1'b1, HA_HALTED, 32'h0);
        dmi_rd(DM_STATUS);
        chk("allhalted", 1'b1, dq[2 + ST_ALLHALT]);
        dmi(OP_WRITE, DM_ABSCS, 32'h0000_0700);
        dmi(OP_WRITE, DM_COMMAND, 32'h0101_1005);
        dmi_rd(DM_ABSCS);
        chk("cmderr unsup", CMDERR_UNSUP, dq[12:10]);
        dmi(OP_WRITE, DM_ABSCS, 32'h0000_0700);
        dmi(OP_WRITE, DM_COMMAND, 32'h0001_1005);
        hart(1'b0, 1'b1, HA_GO, 32'h0);
        chk("go word", 8'h95, hd[7:0]);
        dmi(OP_WRITE, DM_COMMAND, 32'h0001_1005);
        dmi_rd(DM_ABSCS);
        chk("cmderr busy", {1'b1, CMDERR_BUSY}, {dq[14], dq[12:10]});
        hart(1'b1, 1'b1, HA_DONE, 32'h0);
        hart(1'b0, 1'b1, HA_GO, 32'h0);
        chk("go done", 8'h94, hd[7:0]);
        hart(1'b1, 1'b1, HA_RESUMING, 32'h0);
        dmi_rd(DM_STATUS);
        chk("running", 2'b10, {dq[2 + ST_ALLRUN], dq[2 + ST_ALLHALT]});
        $display("test command done");
        @(posedge mclk);
        #1 rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (4) @(posedge mclk);
        hart(1'b0, 1'b1, HA_DATA0, 32'h0);
        chk("reset data0", 32'h0, hd);
        $display("test port reset done");
        results();
    end
endmodule
